/* File: sim/lss_host_model.sv */
// lss_host_model: host side of the register port, one byte per access.
// assumes its task is called at a falling clock edge.
`timescale 1ns/100ps

module lss_host_model (
	// clock
	input wire logic core_clk_i,
	// answer from the block
	input wire logic [7:0] host_rdata_i,
	input wire logic host_ack_i,
	// request to the block
	output logic host_rd_o,
	output logic host_wr_o,
	output logic [7:0] host_addr_o,
	output logic [7:0] host_wdata_o
);

	////////////////////////////////////////////////////////////////////////
	// idle: fields park on inverted values so stale data never looks valid
	initial
	begin
		host_rd_o = 1'b0;
		host_wr_o = 1'b0;
		host_addr_o = 8'hA5;
		host_wdata_o = 8'h5A;
	end

	// strobe one cycle, then always wait four cycles, taking the first answer
	// seen, so the next strobe never lands in the same time step
	task automatic access(input logic rd, input logic [7:0] addr,
		input logic [7:0] wdata, output logic [7:0] rdata, output logic ok);
		host_rd_o = rd;
		host_wr_o = !rd;
		host_addr_o = addr;
		host_wdata_o = wdata;
		@(negedge core_clk_i);
		host_rd_o = 1'b0;
		host_wr_o = 1'b0;
		host_addr_o = ~addr;
		host_wdata_o = ~wdata;
		ok = 1'b0;
		rdata = 8'h00;
		repeat (4)
		begin
			if (!ok && host_ack_i === 1'b1)
			begin
				ok = 1'b1;
				rdata = host_rdata_i;
			end
			@(negedge core_clk_i);
		end
	endtask

endmodule // lss_host_model

/* File: sim/lss_status_top_properties.sv */
// lss_status_top_properties: port checks on the link safety status block.
// assumes one clock domain and status reads at the read address.
`timescale 1ns/100ps
`include "lss_map.svh"

module lss_status_checker import lss_pkg::*; (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// host port
	input wire logic host_rd_i,
	input wire logic host_wr_i,
	input wire logic [7:0] host_addr_i,
	input wire logic [7:0] host_rdata_o,
	input wire logic host_ack_o,
	// causes behind the flags
	input wire logic alert_link_error_i,
	input wire logic alert_buffer_fault_i,
	input wire logic echo_mismatch_i,
	input wire lss_mode_type op_mode_i,
	input wire lss_alive_mode_type alive_mode_i,
	input wire logic [7:0] rolling_count_queue_i,
	input wire logic seed_clear_command_i,
	input wire logic logic_fault_i
);

	////////////////////////////////////////////////////////////////////////
	// status read decode
	wire logic rd_status = host_rd_i && host_addr_i == `LSS_ADDR_STATUS_RD;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);

	////////////////////////////////////////////////////////////////////////
	// host port answers
	a_ack_follows: assert property ((host_rd_i || host_wr_i) |=> host_ack_o)
		else $error("access without answer strobe");
	a_ack_single: assert property (!(host_rd_i || host_wr_i) |=> !host_ack_o)
		else $error("answer strobe without access");
	a_write_no_data: assert property (
		!host_rd_i |=> host_rdata_o == 8'h00)
		else $error("read data without a read");
	a_unmapped_zero: assert property (
		host_rd_i && !rd_status |=> host_rdata_o == `LSS_READ_DEFAULT)
		else $error("unmapped read not zero");
	a_reset_value: assert property (
		$rose(nrst_i) && rd_status |=> host_rdata_o == `LSS_STATUS_RESET)
		else $error("status not at reset value");

	////////////////////////////////////////////////////////////////////////
	// flags tied to their causes; the guard keeps reset-time history out
	a_host_state_bit: assert property (
		rd_status && $past(nrst_i) |=> host_rdata_o[`LSS_BIT_HOST_DRIVEN] ==
		($past(op_mode_i, 2) == LSS_MODE_COMMANDED))
		else $error("host driven bit wrong");
	a_alert_summary: assert property (
		rd_status && $past(nrst_i) |=> host_rdata_o[`LSS_BIT_ALERT_SUMMARY] ==
		$past(alert_link_error_i || alert_buffer_fault_i, 2))
		else $error("alert summary bit wrong");
	a_echo_flag_set: assert property (
		echo_mismatch_i ##1 rd_status |=> host_rdata_o[`LSS_BIT_ECHO_MISMATCH])
		else $error("echo mismatch not flagged");
	a_hw_fault_set: assert property (
		logic_fault_i ##1 rd_status |=> host_rdata_o[`LSS_BIT_HW_FAULT])
		else $error("hardware fault not flagged");
	a_seed_clear_err: assert property (
		seed_clear_command_i && rolling_count_queue_i != 8'h00 &&
		alive_mode_i == LSS_ALIVE_AUTO ##1 rd_status
		|=> host_rdata_o[`LSS_BIT_ROLLING_COUNT])
		else $error("seed clear with queued counts not flagged");

endmodule // lss_status_checker

bind lss_status_top lss_status_checker u_lss_status_checker (
	.core_clk_i, .nrst_i, .host_rd_i, .host_wr_i, .host_addr_i,
	.host_rdata_o, .host_ack_o, .alert_link_error_i, .alert_buffer_fault_i,
	.echo_mismatch_i, .op_mode_i, .alive_mode_i, .rolling_count_queue_i,
	.seed_clear_command_i, .logic_fault_i
);

/* File: sim/lss_status_top_test.sv */
// lss_status_top_test: drives every flag cause and reads the byte back.
// assumes the host model answers within a few cycles.
`timescale 1ns/100ps
`include "lss_map.svh"

module lss_status_top_test import lss_pkg::*; ();

	logic core_clk_i = 1'b0;
	logic nrst_i, host_rd_i, host_wr_i, host_ack_o, ok;
	logic [7:0] host_addr_i, host_wdata_i, host_rdata_o, d;
	logic rx_msg_done_i, rx_buf_empty_i, rx_msg_auto_i, rx_msg_read_i;
	logic alert_pkt_valid_i, debounce_done_i, alert_link_error_i;
	logic alert_buffer_fault_i, preamble_i, frame_end_i, data_corrupt_i;
	logic echo_mismatch_i, count_check_i, count_broadcast_i;
	logic seed_clear_command_i, supply_fault_i, osc_fault_i, logic_fault_i;
	logic [7:0] alert_status_i, err_mask_i, debounce_mask_set_i;
	logic [7:0] returned_rolling_count_i, rolling_count_seed_i;
	logic [7:0] rolling_count_queue_i, chain_node_total_i;
	lss_mode_type op_mode_i = LSS_MODE_COMMANDED;
	lss_alive_mode_type alive_mode_i = LSS_ALIVE_OFF;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////
	// clock, hang guard and instances
	always #50 core_clk_i = ~core_clk_i;

	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			test_done();
		end
	end

	lss_status_top u_lss_status_top (.core_clk_i, .nrst_i, .host_rd_i,
		.host_wr_i, .host_addr_i, .host_wdata_i, .host_rdata_o, .host_ack_o,
		.rx_msg_done_i, .rx_buf_empty_i, .rx_msg_auto_i, .rx_msg_read_i,
		.alert_pkt_valid_i, .alert_status_i, .err_mask_i, .debounce_mask_set_i,
		.debounce_done_i, .alert_link_error_i, .alert_buffer_fault_i,
		.preamble_i, .frame_end_i, .data_corrupt_i, .echo_mismatch_i,
		.op_mode_i, .alive_mode_i, .count_check_i, .count_broadcast_i,
		.returned_rolling_count_i, .rolling_count_seed_i,
		.rolling_count_queue_i, .chain_node_total_i, .seed_clear_command_i,
		.supply_fault_i, .osc_fault_i, .logic_fault_i);

	lss_host_model u_lss_host_model (.core_clk_i, .host_rdata_i(host_rdata_o),
		.host_ack_i(host_ack_o), .host_rd_o(host_rd_i), .host_wr_o(host_wr_i),
		.host_addr_o(host_addr_i), .host_wdata_o(host_wdata_i));

	////////////////////////////////////////////////////////////////////////
	// helpers
	task check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// a missing answer strobe spoils the value so it cannot match
	task st(input string what, input logic [7:0] exp);
		u_lss_host_model.access(1'b1, `LSS_ADDR_STATUS_RD, 8'h00, d, ok);
		check(what, ok ? d : 8'hXX, exp);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge core_clk_i);
		s = 1'b0;
	endtask

	task test_done();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{rx_msg_done_i, rx_buf_empty_i, rx_msg_auto_i, rx_msg_read_i,
			alert_pkt_valid_i, debounce_done_i, alert_link_error_i,
			alert_buffer_fault_i, preamble_i, frame_end_i, data_corrupt_i,
			echo_mismatch_i, count_check_i, count_broadcast_i,
			seed_clear_command_i, supply_fault_i, osc_fault_i, logic_fault_i,
			alert_status_i, err_mask_i, debounce_mask_set_i} = '0;
		{returned_rolling_count_i, rolling_count_seed_i} = '0;
		{rolling_count_queue_i, chain_node_total_i} = '0;
		nrst_i = 1'b0;
		repeat (5) @(negedge core_clk_i);
		nrst_i = 1'b1;
		st("reset value", 8'h04);
		u_lss_host_model.access(1'b0, `LSS_ADDR_STATUS_WR, 8'hFF, d, ok);
		check("write ack", {7'h00, ok}, 8'h01);
		st("after write", 8'h04);
		u_lss_host_model.access(1'b1, 8'h06, 8'h00, d, ok);
		check("unmapped", d, 8'h00);
		// receive messages: empty stop and automatic ones do not count
		rx_buf_empty_i = 1'b1;
		pulse(rx_msg_done_i);
		rx_buf_empty_i = 1'b0;
		st("empty stop", 8'h04);
		rx_msg_auto_i = 1'b1;
		pulse(rx_msg_done_i);
		rx_msg_auto_i = 1'b0;
		st("auto message", 8'h04);
		pulse(rx_msg_done_i);
		pulse(rx_msg_done_i);
		st("two messages", 8'h84);
		pulse(rx_msg_read_i);
		st("one unread", 8'h84);
		pulse(rx_msg_read_i);
		st("all read", 8'h04);
		// alert status masking differs per mode
		err_mask_i = 8'h0F;
		debounce_mask_set_i = 8'hF0;
		alert_status_i = 8'h01;
		pulse(alert_pkt_valid_i);
		st("masked alert", 8'h04);
		alert_status_i = 8'h10;
		pulse(alert_pkt_valid_i);
		st("unmasked alert", 8'h44);
		op_mode_i = LSS_MODE_SLEEP;
		pulse(debounce_done_i);
		st("sleep debounced", 8'h00);
		pulse(alert_pkt_valid_i);
		st("debounce masked", 8'h00);
		alert_status_i = 8'h01;
		pulse(alert_pkt_valid_i);
		st("sleep alert", 8'h40);
		op_mode_i = LSS_MODE_SAFE_MON;
		pulse(debounce_done_i);
		st("safe debounced", 8'h00);
		op_mode_i = LSS_MODE_COMMANDED;
		// link corruption counts only inside a frame, at its end
		pulse(data_corrupt_i);
		pulse(frame_end_i);
		st("idle corrupt", 8'h04);
		pulse(preamble_i);
		pulse(data_corrupt_i);
		st("corrupt open", 8'h04);
		pulse(frame_end_i);
		st("corrupt done", 8'h24);
		pulse(preamble_i);
		st("preamble", 8'h04);
		pulse(echo_mismatch_i);
		st("echo mismatch", 8'h0C);
		pulse(preamble_i);
		for (int i = 1; i < 4; i++)
		begin
			{alert_link_error_i, alert_buffer_fault_i} = 2'(i);
			@(negedge core_clk_i);
			st("alert summary", 8'h14);
		end
		{alert_link_error_i, alert_buffer_fault_i} = 2'h0;
		@(negedge core_clk_i);
		st("summary clear", 8'h04);
		// rolling counter: seed 0x10, queue 3, five nodes
		{rolling_count_seed_i, rolling_count_queue_i} = 16'h1003;
		chain_node_total_i = 8'h05;
		count_broadcast_i = 1'b1;
		returned_rolling_count_i = 8'h13;
		for (int i = 0; i < 2; i++)
		begin
			alive_mode_i = lss_alive_mode_type'(i);
			pulse(count_check_i);
			pulse(seed_clear_command_i);
			st("count off", 8'h04);
		end
		alive_mode_i = LSS_ALIVE_AUTO;
		for (int i = 0; i < 4; i++)
		begin
			count_broadcast_i = i < 2;
			returned_rolling_count_i = i == 0 ? 8'h12 : i == 2 ? 8'h0E : 8'h12;
			if (i == 1)
				returned_rolling_count_i = 8'h13;
			pulse(count_check_i);
			st("count check", i[0] ? 8'h06 : 8'h04);
			rolling_count_queue_i = 8'h00;
			pulse(seed_clear_command_i);
			rolling_count_queue_i = 8'h03;
		end
		pulse(seed_clear_command_i);
		st("queued seed clear", 8'h06);
		rolling_count_queue_i = 8'h00;
		pulse(seed_clear_command_i);
		// each hardware fault is sticky until a reset in mid-run
		for (int f = 0; f < 3; f++)
		begin
			{supply_fault_i, osc_fault_i, logic_fault_i} = 3'(3'h4 >> f);
			repeat (3) @(negedge core_clk_i);
			{supply_fault_i, osc_fault_i, logic_fault_i} = 3'h0;
			st("hardware fault", 8'h05);
			st("fault sticky", 8'h05);
			nrst_i = 1'b0;
			@(negedge core_clk_i);
			nrst_i = 1'b1;
			st("reset again", 8'h04);
		end
		test_done();
	end

endmodule // lss_status_top_test

/* File: verilog/lss_alive_check.sv */
// lss_alive_check: compares a returned rolling counter byte with the
// value expected from seed, queue depth and chain length.
// assumes all inputs are steady in the cycle check_i or seed_clear_i is high.
`timescale 1ns/100ps
`include "lss_map.svh"

module lss_alive_check import lss_pkg::*; (
	// configuration
	input wire lss_alive_mode_type alive_mode_i,
	input wire logic [7:0] rolling_count_seed_i,
	input wire logic [7:0] rolling_count_queue_i,
	input wire logic [7:0] chain_node_total_i,
	// events
	input wire logic check_i,
	input wire logic broadcast_i,
	input wire logic [7:0] returned_rolling_count_i,
	input wire logic seed_clear_i,
	// results
	output logic err_set_o,
	output logic err_clear_o
);

	logic auto_on;
	logic [7:0] step;
	logic [7:0] expected;
	logic count_bad;
	logic clear_bad;

	// only the automatic mode may ever raise the error
	assign auto_on = (alive_mode_i == LSS_ALIVE_AUTO); // RL15
	// broadcast commands pass every node, single-node ones only one
	assign step = broadcast_i ? chain_node_total_i : `LSS_SINGLE_NODE_STEP;
	// modulo-256 arithmetic, as the counter byte wraps
	assign expected = 8'(rolling_count_seed_i - rolling_count_queue_i + step);
	assign count_bad = check_i && (returned_rolling_count_i != expected); // RL13
	// clearing the seed with commands still queued loses track
	assign clear_bad = seed_clear_i && (rolling_count_queue_i != 8'h00); // RL14
	assign err_set_o = auto_on && (count_bad || clear_bad); // RL15
	// a clean seed clear restarts counting, so the old error is dropped
	assign err_clear_o = seed_clear_i && (rolling_count_queue_i == 8'h00);

endmodule // lss_alive_check

/* File: verilog/lss_flag.sv */
// lss_flag: one sticky status flag with set and clear pulses.
// assumes set and clear come from logic on the same clock.
`timescale 1ns/100ps

module lss_flag #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// control
	input wire logic set_i,
	input wire logic clear_i,
	// state
	output logic flag_o
);

	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			flag_o <= RESET_VAL;
		else if (set_i)
			flag_o <= 1'b1;
		else if (clear_i)
			flag_o <= 1'b0;
	end

endmodule // lss_flag

/* File: verilog/lss_map.svh */
// lss_map.svh: offsets, bit positions, reset value and small counts of the
// link safety status byte.
// assumes it is included by bare name wherever the numbers are needed.
`ifndef LSS_MAP_SVH
`define LSS_MAP_SVH

////////////////////////////////////////////////////////////////////////////
// host port addresses: read and write forms of the same register
`define LSS_ADDR_STATUS_RD 8'h05
`define LSS_ADDR_STATUS_WR 8'h04

////////////////////////////////////////////////////////////////////////////
// field positions inside the status byte
`define LSS_BIT_MSG_READY 7
`define LSS_BIT_ALERT_STATUS 6
`define LSS_BIT_LINK_CORRUPT 5
`define LSS_BIT_ALERT_SUMMARY 4
`define LSS_BIT_ECHO_MISMATCH 3
`define LSS_BIT_HOST_DRIVEN 2
`define LSS_BIT_ROLLING_COUNT 1
`define LSS_BIT_HW_FAULT 0

////////////////////////////////////////////////////////////////////////////
// reset value: only the host-driven state bit is high
`define LSS_STATUS_RESET 8'h04
// answer for any address other than the status read address
`define LSS_READ_DEFAULT 8'h00
// increment for single-node commands in the rolling counter check
`define LSS_SINGLE_NODE_STEP 8'h01

`endif

/* File: verilog/lss_pkg.sv */
// lss_pkg: types shared by the link safety status block.
// assumes nothing beyond a SystemVerilog compiler.
package lss_pkg;

	// operating mode reported by the mode controller
	typedef enum logic [1:0]
	{
		LSS_MODE_COMMANDED,
		LSS_MODE_SLEEP,
		LSS_MODE_SAFE_MON
	} lss_mode_type;

	// rolling counter configuration
	typedef enum logic [1:0]
	{
		LSS_ALIVE_OFF,
		LSS_ALIVE_MANUAL,
		LSS_ALIVE_AUTO
	} lss_alive_mode_type;

	// link frame tracking
	typedef enum logic
	{
		LSS_LINK_IDLE,
		LSS_LINK_IN_FRAME
	} lss_link_state_type;

endpackage

/* File: verilog/lss_status_top.sv */
// lss_status_top: the link safety status byte and the logic behind each
// of its flags, read by the host over the register access port.
// assumes the link datapath, alert buffer, mask registers, mode control and
// counter configuration run on core_clk_i; supply and oscillator monitors
// are asynchronous and are synchronised here.
//
// Function
// RL1: set message-ready bit 7 when a framed received message waits for reading.
// RL2: clear message-ready once the host has read every unread message.
// RL3: a stop character with an empty receive buffer leaves message-ready clear.
// RL4: automatic alert-packet transactions never raise message-ready.
// RL5: raise bit 6 when an unmasked alert-packet status bit arrives.
// RL6: in host-driven operation the error-mask set masks alert status bits.
// RL7: in sleep or safe monitoring use debounce masks; auto-clear on debounce.
// RL8: bit 5 flags corrupted, inserted or omitted data within a link message.
// RL9: clear bit 5 on a preamble; set it when an erroneous transaction ends.
// RL10: bit 4 is the OR of alert link error and alert buffer fault.
// RL11: bit 3 flags echoed link data differing from transmitted data.
// RL12: bit 2 is one in host-driven operation, zero in sleep or safe mode.
// RL13: bit 1 flags a returned counter byte differing from the expected value.
// RL14: bit 1 also flags a seed clear while the counter queue is non-zero.
// RL15: bit 1 is never set while counting is disabled or manual.
// RL16: bit 0 flags supply, oscillator or transient logic faults.
// RL17: reset value 0x04; host writes to the byte change nothing.
`timescale 1ns/100ps
`include "lss_map.svh"

module lss_status_top import lss_pkg::*; #(
	parameter int ALERT_W = 8,
	parameter int MSG_CNT_W = 4
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic nrst_i,
	// host register access
	input wire logic host_rd_i,
	input wire logic host_wr_i,
	input wire logic [7:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	output logic [7:0] host_rdata_o,
	output logic host_ack_o,
	// receive side of the link
	input wire logic rx_msg_done_i,
	input wire logic rx_buf_empty_i,
	input wire logic rx_msg_auto_i,
	input wire logic rx_msg_read_i,
	// alert packet buffer
	input wire logic alert_pkt_valid_i,
	input wire logic [ALERT_W-1:0] alert_status_i,
	input wire logic [ALERT_W-1:0] err_mask_i,
	input wire logic [ALERT_W-1:0] debounce_mask_set_i,
	input wire logic debounce_done_i,
	input wire logic alert_link_error_i,
	input wire logic alert_buffer_fault_i,
	// link framing and lock-step monitor
	input wire logic preamble_i,
	input wire logic frame_end_i,
	input wire logic data_corrupt_i,
	input wire logic echo_mismatch_i,
	// operating mode
	input wire lss_mode_type op_mode_i,
	// rolling counter
	input wire lss_alive_mode_type alive_mode_i,
	input wire logic count_check_i,
	input wire logic count_broadcast_i,
	input wire logic [7:0] returned_rolling_count_i,
	input wire logic [7:0] rolling_count_seed_i,
	input wire logic [7:0] rolling_count_queue_i,
	input wire logic [7:0] chain_node_total_i,
	input wire logic seed_clear_command_i,
	// hardware monitors
	input wire logic supply_fault_i,
	input wire logic osc_fault_i,
	input wire logic logic_fault_i
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [MSG_CNT_W-1:0] unread_count, next_unread_count;
	logic msg_accept, msg_take, cnt_full, cnt_empty, msg_ready;

	logic host_driven, host_driven_state;
	logic [ALERT_W-1:0] active_mask;
	logic alert_unmasked, alert_set, alert_clear, alert_status_error;

	lss_link_state_type link_state, next_link_state;
	logic frame_err_pending, next_frame_err_pending;
	logic link_set, link_corruption_error;

	logic alert_summary_error, echo_mismatch_error;
	logic alive_set, alive_clear, rolling_counter_error;

	logic supply_meta, supply_sync, osc_meta, osc_sync;
	logic hw_set, hardware_fault;

	logic [7:0] status_byte, next_rdata;
	logic rd_hit, access;

	////////////////////////////////////////////////////////////////////////
	// unread message counter behind the message-ready flag

	// a message counts only if framed, non-empty and host-originated
	assign msg_accept = rx_msg_done_i && !rx_buf_empty_i // RL3
		&& !rx_msg_auto_i; // RL4
	assign cnt_full = (unread_count == {MSG_CNT_W{1'b1}});
	assign cnt_empty = (unread_count == '0);
	// a read with nothing counted is ignored, so the count never wraps
	assign msg_take = rx_msg_read_i && !cnt_empty;

	// saturate rather than wrap: the receive buffer overflows long before
	always_comb
	begin
		next_unread_count = unread_count;
		if (msg_accept && !msg_take && !cnt_full)
			next_unread_count = unread_count + 1'b1; // RL1
		else if (msg_take && !msg_accept)
			next_unread_count = unread_count - 1'b1; // RL2
	end

	// counter register
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			unread_count <= '0;
		else
			unread_count <= next_unread_count;
	end

	// ready as long as one message is still unread
	assign msg_ready = !cnt_empty; // RL1 RL2

	////////////////////////////////////////////////////////////////////////
	// operating mode

	// any mode other than host-driven counts as sleep or safe monitoring
	assign host_driven = (op_mode_i == LSS_MODE_COMMANDED);

	// registered so the byte never shows a decoder glitch
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			host_driven_state <= 1'b1; // RL17
		else
			host_driven_state <= host_driven; // RL12
	end

	////////////////////////////////////////////////////////////////////////
	// alert packet status error

	// mask set follows the mode; a mask bit of one hides that status
	assign active_mask = host_driven ? err_mask_i // RL6
		: debounce_mask_set_i; // RL7
	assign alert_unmasked = |(alert_status_i & ~active_mask); // RL5
	assign alert_set = alert_pkt_valid_i && alert_unmasked; // RL5
	// host-driven: a clean packet clears; otherwise debounce clears it
	assign alert_clear = host_driven
		? (alert_pkt_valid_i && !alert_unmasked)
		: debounce_done_i; // RL7

	lss_flag #(
		.RESET_VAL(1'b0)
	) u_alert_flag (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.set_i(alert_set),
		.clear_i(alert_clear),
		.flag_o(alert_status_error)
	);

	////////////////////////////////////////////////////////////////////////
	// link corruption error: frame tracking

	// errors seen inside a frame wait until that frame ends
	always_comb
	begin
		next_link_state = link_state;
		next_frame_err_pending = frame_err_pending;
		case (link_state)
			LSS_LINK_IDLE:
			begin
				if (preamble_i)
				begin
					next_link_state = LSS_LINK_IN_FRAME;
					next_frame_err_pending = data_corrupt_i; // RL8
				end
			end
			LSS_LINK_IN_FRAME:
			begin
				if (preamble_i)
					next_frame_err_pending = data_corrupt_i; // RL9
				else if (frame_end_i)
				begin
					next_link_state = LSS_LINK_IDLE;
					next_frame_err_pending = 1'b0;
				end
				else if (data_corrupt_i)
					next_frame_err_pending = 1'b1; // RL8
			end
			default:
			begin
				next_link_state = LSS_LINK_IDLE;
				next_frame_err_pending = 1'b0;
			end
		endcase
	end

	// frame tracker registers
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			link_state <= LSS_LINK_IDLE;
			frame_err_pending <= 1'b0;
		end
		else
		begin
			link_state <= next_link_state;
			frame_err_pending <= next_frame_err_pending;
		end
	end

	// set only at the end of a frame that carried an error
	assign link_set = (link_state == LSS_LINK_IN_FRAME) && frame_end_i
		&& !preamble_i && (frame_err_pending || data_corrupt_i); // RL9

	lss_flag #(
		.RESET_VAL(1'b0)
	) u_link_flag (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.set_i(link_set),
		.clear_i(preamble_i), // RL9
		.flag_o(link_corruption_error)
	);

	////////////////////////////////////////////////////////////////////////
	// alert summary: follows its two sources, one cycle late

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			alert_summary_error <= 1'b0;
		else
			alert_summary_error <= alert_link_error_i
				|| alert_buffer_fault_i; // RL10
	end

	////////////////////////////////////////////////////////////////////////
	// echo mismatch from the lock-step monitor

	// sticky through the frame; a new preamble starts a fresh comparison
	lss_flag #(
		.RESET_VAL(1'b0)
	) u_echo_flag (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.set_i(echo_mismatch_i), // RL11
		.clear_i(preamble_i),
		.flag_o(echo_mismatch_error)
	);

	////////////////////////////////////////////////////////////////////////
	// rolling counter error

	lss_alive_check u_alive_check (
		.alive_mode_i(alive_mode_i),
		.rolling_count_seed_i(rolling_count_seed_i),
		.rolling_count_queue_i(rolling_count_queue_i),
		.chain_node_total_i(chain_node_total_i),
		.check_i(count_check_i),
		.broadcast_i(count_broadcast_i),
		.returned_rolling_count_i(returned_rolling_count_i),
		.seed_clear_i(seed_clear_command_i),
		.err_set_o(alive_set),
		.err_clear_o(alive_clear)
	);

	lss_flag #(
		.RESET_VAL(1'b0)
	) u_alive_flag (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.set_i(alive_set), // RL13 RL14 RL15
		.clear_i(alive_clear),
		.flag_o(rolling_counter_error)
	);

	////////////////////////////////////////////////////////////////////////
	// hardware fault

	// supply and oscillator monitor outputs are asynchronous: two stages before any use
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			supply_meta <= 1'b0;
			supply_sync <= 1'b0;
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
		end
		else
		begin
			supply_meta <= supply_fault_i;
			supply_sync <= supply_meta;
			osc_meta <= osc_fault_i;
			osc_sync <= osc_meta;
		end
	end

	// only reset clears it: a fault may have upset any other state
	assign hw_set = supply_sync || osc_sync || logic_fault_i; // RL16

	lss_flag #(
		.RESET_VAL(1'b0)
	) u_hw_flag (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.set_i(hw_set), // RL16
		.clear_i(1'b0),
		.flag_o(hardware_fault)
	);

	////////////////////////////////////////////////////////////////////////
	// status byte assembly and host access

	// all fields come from flip-flops, so the reset image is 0x04
	always_comb
	begin
		status_byte = `LSS_STATUS_RESET;
		status_byte[`LSS_BIT_MSG_READY] = msg_ready;
		status_byte[`LSS_BIT_ALERT_STATUS] = alert_status_error;
		status_byte[`LSS_BIT_LINK_CORRUPT] = link_corruption_error;
		status_byte[`LSS_BIT_ALERT_SUMMARY] = alert_summary_error;
		status_byte[`LSS_BIT_ECHO_MISMATCH] = echo_mismatch_error;
		status_byte[`LSS_BIT_HOST_DRIVEN] = host_driven_state;
		status_byte[`LSS_BIT_ROLLING_COUNT] = rolling_counter_error;
		status_byte[`LSS_BIT_HW_FAULT] = hardware_fault;
	end

	// writes are answered but discarded; data bus is never stored
	assign rd_hit = host_rd_i && (host_addr_i == `LSS_ADDR_STATUS_RD);
	assign access = host_rd_i || host_wr_i; // RL17
	assign next_rdata = rd_hit ? status_byte : `LSS_READ_DEFAULT;

	// answer one cycle after the access; the byte is a snapshot
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			host_rdata_o <= `LSS_READ_DEFAULT;
			host_ack_o <= 1'b0;
		end
		else
		begin
			host_rdata_o <= access ? next_rdata : `LSS_READ_DEFAULT;
			host_ack_o <= access;
		end
	end

endmodule // lss_status_top
